// file: logic/flash_guard_pkg.sv
// Constants and types for the flash sector access guard
package flash_guard_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam logic [15:0] SECTOR_SIZE = 16'h1000;
    localparam logic [15:0] SECTOR0_BASE = 16'hf000;
    localparam logic [15:0] SECTOR1_BASE = 16'he000;
    localparam logic [15:0] ADDR_TOP = 16'hffff;
    localparam logic [16:0] SIZE_4K = 17'h01000;
    localparam logic [16:0] SIZE_8K = 17'h02000;
    localparam logic [16:0] ARRAY_SIZE_DEFAULT = 17'h08000;
    localparam logic [7:0] UNLOCK_KEY1 = 8'h56;
    localparam logic [7:0] UNLOCK_KEY2 = 8'hae;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [1:0] SECTOR_NONE = 2'h3;
    localparam logic [1:0] OPT_PROTECT_BIT = 2'h0;
    localparam int OPT_BYTES = 2;

    typedef enum logic [1:0]
    {
        MODE_USER,
        MODE_TOOL,
        MODE_ICP,
        MODE_IAP
    } prog_mode_t;

    typedef enum logic [1:0]
    {
        OP_PROGRAM,
        OP_ERASE_SECTOR,
        OP_ERASE_ALL,
        OP_PROGRAM_OPTION
    } op_t;
endpackage : flash_guard_pkg

// file: logic/flash_sector_access_guard.sv
// Flash sector map, access guard and byte-wide program/erase engine
// What this block does
// RQ1 - Erasing one sector leaves every other sector untouched.
// RQ2 - Programs one byte per request; erases whole array or one sector.
// RQ3 - Sectors 0 and 1 are 4 Kbytes each; remaining space is sector 2.
// RQ4 - Sector 0 sits at F000h-FFFFh, holding reset and interrupt vectors.
// RQ5 - 4K array has sector 0; 8K adds sector 1; larger adds sector 2.
// RQ6 - In-application mode may write any sector except sector 0.
// RQ7 - Tool and in-circuit modes may write all sectors and option bytes.
// RQ8 - No write or erase unless the security sequence precedes it.
// RQ9 - Removing read-out protection clears the bit at once, then erases the whole array.
// RQ10 - Refused requests change neither array nor option bytes.
`timescale 1ns/1ps
module flash_sector_access_guard
    import flash_guard_pkg::*;
#(
    parameter logic [16:0] ARRAY_SIZE = ARRAY_SIZE_DEFAULT
)
(
    input wire logic clk,
    input wire logic srst,
    input wire prog_mode_t mode,
    input wire logic key_valid,
    input wire logic [7:0] key_data,
    input wire logic req_valid,
    input wire op_t req_op,
    input wire logic [15:0] req_addr,
    input wire logic [7:0] req_data,
    input wire logic rd_valid,
    input wire logic [15:0] rd_addr,
    output logic [7:0] rd_data,
    output logic rd_ack,
    output logic req_done,
    output logic req_refused,
    output logic unlocked,
    output logic busy,
    output logic [7:0] option0,
    output logic [7:0] option1
);
    localparam logic [16:0] ARRAY_BASE17 = 17'h10000 - ARRAY_SIZE;
    localparam logic [15:0] ARRAY_BASE = ARRAY_BASE17[15:0];

    typedef enum logic [1:0]
    {
        ST_IDLE,
        ST_ERASE,
        ST_RELOCK
    } state_t;

    typedef enum logic
    {
        KEY_FIRST,
        KEY_SECOND
    } key_state_t;

    logic [7:0] mem [0:65535];
    key_state_t key_state_reg, key_state_next;
    logic busy_reg, busy_next;
    logic unlocked_reg, unlocked_next;
    state_t state_reg, state_next;
    logic [15:0] ptr_reg, ptr_next;
    logic [15:0] end_reg, end_next;
    logic [7:0] opt0_reg, opt0_next;
    logic [7:0] opt1_reg, opt1_next;
    logic done_reg, done_next;
    logic refused_reg, refused_next;
    logic [7:0] rd_data_reg;
    logic rd_ack_reg;
    logic wr_en;
    logic [15:0] wr_addr;
    logic [7:0] wr_byte;
    logic [1:0] req_sector;
    logic allowed;

    // Sector decode for the configured array size
    always_comb
    begin
        req_sector = SECTOR_NONE;
        if (req_addr >= SECTOR0_BASE) // RQ4
            req_sector = 2'h0;
        else if (req_addr >= SECTOR1_BASE && ARRAY_SIZE >= SIZE_8K) // RQ3 RQ5
            req_sector = 2'h1;
        else if (req_addr >= ARRAY_BASE && ARRAY_SIZE > SIZE_8K) // RQ5
            req_sector = 2'h2;
    end

    // Permission check per mode
    always_comb
    begin
        allowed = 1'b0;
        case (mode)
            MODE_TOOL, MODE_ICP: // RQ7
                allowed = (req_op == OP_PROGRAM_OPTION) ? (req_addr < 16'(OPT_BYTES)) :
                          (req_op == OP_ERASE_ALL) ? 1'b1 : (req_sector != SECTOR_NONE);
            MODE_IAP: // RQ6
                allowed = (req_op == OP_PROGRAM || req_op == OP_ERASE_SECTOR) &&
                          req_sector != SECTOR_NONE && req_sector != 2'h0;
            default:
                allowed = 1'b0;
        endcase
        allowed = allowed && unlocked_reg; // RQ8
    end

    // Security sequence, request handling and erase walk
    always_comb
    begin
        key_state_next = key_state_reg;
        unlocked_next = unlocked_reg;
        state_next = state_reg;
        ptr_next = ptr_reg;
        end_next = end_reg;
        opt0_next = opt0_reg;
        opt1_next = opt1_reg;
        done_next = 1'b0;
        refused_next = 1'b0;
        wr_en = 1'b0;
        wr_addr = ptr_reg;
        wr_byte = ERASED_BYTE;
        case (state_reg)
            ST_IDLE:
            begin
                if (req_valid)
                begin
                    unlocked_next = 1'b0; // RQ8
                    key_state_next = KEY_FIRST;
                    if (!allowed)
                        refused_next = 1'b1; // RQ10
                    else
                    begin
                        case (req_op)
                            OP_PROGRAM: // RQ2
                            begin
                                wr_en = 1'b1;
                                wr_addr = req_addr;
                                wr_byte = req_data;
                                done_next = 1'b1;
                            end
                            OP_ERASE_SECTOR: // RQ1 RQ2
                            begin
                                state_next = ST_ERASE;
                                ptr_next = (req_sector == 2'h2) ? ARRAY_BASE :
                                           {req_addr[15:12], 12'h000};
                                end_next = (req_sector == 2'h2) ? (SECTOR1_BASE - 16'h0001) :
                                           {req_addr[15:12], 12'hfff};
                            end
                            OP_ERASE_ALL: // RQ2
                            begin
                                state_next = ST_ERASE;
                                ptr_next = ARRAY_BASE;
                                end_next = ADDR_TOP;
                            end
                            default: // Option bytes
                            begin
                                if (req_addr[0] == 1'b0)
                                begin
                                    opt0_next = req_data;
                                    // Clearing protection updates option0 at once, then wipes the array
                                    if (opt0_reg[OPT_PROTECT_BIT] && !req_data[OPT_PROTECT_BIT])
                                    begin
                                        state_next = ST_ERASE; // RQ9
                                        ptr_next = ARRAY_BASE;
                                        end_next = ADDR_TOP;
                                    end
                                    else
                                        done_next = 1'b1;
                                end
                                else
                                begin
                                    opt1_next = req_data;
                                    done_next = 1'b1;
                                end
                            end
                        endcase
                    end
                end
            end
            ST_ERASE:
            begin
                wr_en = 1'b1;
                ptr_next = ptr_reg + 16'h0001;
                if (ptr_reg == end_reg)
                begin
                    state_next = ST_RELOCK;
                    done_next = 1'b1;
                end
            end
            default:
                state_next = ST_IDLE;
        endcase
        // Key handled after the request so a same-cycle unlock wins
        if (key_valid && state_reg == ST_IDLE) // RQ8
        begin
            if (key_state_reg == KEY_FIRST && key_data == UNLOCK_KEY1)
                key_state_next = KEY_SECOND;
            else if (key_state_reg == KEY_SECOND && key_data == UNLOCK_KEY2)
            begin
                key_state_next = KEY_FIRST;
                unlocked_next = 1'b1;
            end
            else
                key_state_next = KEY_FIRST;
        end
        busy_next = (state_next != ST_IDLE);
    end

    always_ff @(posedge clk)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_byte;
        rd_data_reg <= mem[rd_addr];
        if (srst)
        begin
            key_state_reg <= KEY_FIRST;
            unlocked_reg <= 1'b0;
            state_reg <= ST_IDLE;
            busy_reg <= 1'b0;
            ptr_reg <= 16'h0000;
            end_reg <= 16'h0000;
            opt0_reg <= 8'h00;
            opt1_reg <= 8'h00;
            done_reg <= 1'b0;
            refused_reg <= 1'b0;
            rd_ack_reg <= 1'b0;
        end
        else
        begin
            key_state_reg <= key_state_next;
            unlocked_reg <= unlocked_next;
            state_reg <= state_next;
            busy_reg <= busy_next;
            ptr_reg <= ptr_next;
            end_reg <= end_next;
            opt0_reg <= opt0_next;
            opt1_reg <= opt1_next;
            done_reg <= done_next;
            refused_reg <= refused_next;
            rd_ack_reg <= rd_valid;
        end
    end

    assign rd_data = rd_data_reg;
    assign rd_ack = rd_ack_reg;
    assign req_done = done_reg;
    assign req_refused = refused_reg;
    assign unlocked = unlocked_reg;
    assign busy = busy_reg;
    assign option0 = opt0_reg;
    assign option1 = opt1_reg;
endmodule : flash_sector_access_guard

// file: test/flash_guard_sva.sv
// Port checks for the flash sector access guard
`timescale 1ns/1ps
module flash_guard_sva
    import flash_guard_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire prog_mode_t mode,
    input wire logic key_valid,
    input wire logic req_valid,
    input wire op_t req_op,
    input wire logic [15:0] req_addr,
    input wire logic rd_valid,
    input wire logic rd_ack,
    input wire logic req_done,
    input wire logic req_refused,
    input wire logic unlocked,
    input wire logic busy,
    input wire logic [7:0] option0,
    input wire logic [7:0] option1
);
    logic tk;
    logic sec_pend;
    logic [16:0] busy_cnt;
    assign tk = req_valid && !busy;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Busy cycles of the erase in progress
    always_ff @(posedge clk)
    begin
        if (srst || !busy)
            busy_cnt <= 17'h00000;
        else
            busy_cnt <= busy_cnt + 17'h00001;
    end
    // Last taken request was an unlocked sector 1 erase
    always_ff @(posedge clk)
    begin
        if (srst)
            sec_pend <= 1'b0;
        else if (tk)
            sec_pend <= unlocked && mode != MODE_USER && req_op == OP_ERASE_SECTOR
                && req_addr[15:12] == 4'he;
    end
    sequence s_walk;
        (busy && !req_done) [*8];
    endsequence
    property p_lock; tk && !unlocked |=> req_refused; endproperty
    property p_relock; tk && !key_valid |=> !unlocked; endproperty
    property p_walk_len;
        $fell(busy) && sec_pend |-> busy_cnt == {1'b0, SECTOR_SIZE} + 17'h00001;
    endproperty
    property p_iap_s0;
        tk && mode == MODE_IAP && req_op != OP_PROGRAM_OPTION && req_addr[15:12] == 4'hf
        |=> req_refused;
    endproperty
    property p_prog;
        tk && unlocked && mode == MODE_TOOL && req_op == OP_PROGRAM && req_addr[15]
        |=> req_done && !busy;
    endproperty
    property p_user; tk && mode == MODE_USER |=> req_refused && !req_done; endproperty
    property p_opt;
        tk && mode == MODE_IAP && req_op == OP_PROGRAM_OPTION
        |=> req_refused && $stable(option0) && $stable(option1);
    endproperty
    property p_erase;
        tk && unlocked && mode == MODE_IAP && req_op == OP_ERASE_SECTOR
        && req_addr[15:12] == 4'he |=> s_walk;
    endproperty
    property p_rd; rd_valid |=> rd_ack; endproperty
    a_lock: assert property (p_lock) else $error("request taken while locked");
    a_relock: assert property (p_relock) else $error("unlock not consumed");
    a_iap_s0: assert property (p_iap_s0) else $error("sector 0 write in app mode");
    a_prog: assert property (p_prog) else $error("byte program not done");
    a_user: assert property (p_user) else $error("user mode write");
    a_opt: assert property (p_opt) else $error("option changed in app mode");
    a_erase: assert property (p_erase) else $error("sector erase too short");
    a_rd: assert property (p_rd) else $error("read not acknowledged");
    a_walk_len: assert property (p_walk_len) else $error("sector erase length wrong");
endmodule : flash_guard_sva
bind flash_sector_access_guard flash_guard_sva u_sva (.clk(clk), .srst(srst), .mode(mode),
    .key_valid(key_valid), .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
    .rd_valid(rd_valid), .rd_ack(rd_ack), .req_done(req_done), .req_refused(req_refused),
    .unlocked(unlocked), .busy(busy), .option0(option0), .option1(option1));

// file: test/flash_sector_access_guard_tb_top.sv
// Self-checking testbench for the flash sector access guard
`timescale 1ns/1ps
module flash_sector_access_guard_tb_top;
    import flash_guard_pkg::*;
    typedef struct {prog_mode_t m; op_t op; logic [15:0] a; logic [7:0] d; logic [1:0] r;} row_t;
    logic clk, srst, key_valid, req_valid, rd_valid, rd_ack, req_done, req_refused;
    logic unlocked, busy;
    logic [7:0] key_data, req_data, rd_data, option0, option1;
    logic [15:0] req_addr, rd_addr;
    logic [1:0] r;
    prog_mode_t mode;
    op_t req_op;
    int n_fail = 0;
    int n_compared = 0;
    row_t rows[9] = '{
        '{MODE_TOOL, OP_PROGRAM, 16'h8000, 8'ha5, 2'h2},
        '{MODE_ICP, OP_PROGRAM, 16'hf000, 8'h3c, 2'h2},
        '{MODE_IAP, OP_PROGRAM, 16'he001, 8'h11, 2'h2},
        '{MODE_TOOL, OP_PROGRAM, 16'hdfff, 8'h5a, 2'h2},
        '{MODE_IAP, OP_PROGRAM, 16'hff00, 8'h01, 2'h1},
        '{MODE_USER, OP_PROGRAM, 16'h8001, 8'h02, 2'h1},
        '{MODE_IAP, OP_ERASE_ALL, 16'h8000, 8'h00, 2'h1},
        '{MODE_IAP, OP_PROGRAM_OPTION, 16'h0001, 8'h03, 2'h1},
        '{MODE_TOOL, OP_PROGRAM_OPTION, 16'h0001, 8'h77, 2'h2}};
    flash_sector_access_guard dut (.clk(clk), .srst(srst), .mode(mode), .key_valid(key_valid),
        .key_data(key_data), .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
        .req_data(req_data), .rd_valid(rd_valid), .rd_addr(rd_addr), .rd_data(rd_data),
        .rd_ack(rd_ack), .req_done(req_done), .req_refused(req_refused), .unlocked(unlocked),
        .busy(busy), .option0(option0), .option1(option1));
    flash_tool_model tool (.clk(clk), .req_done(req_done), .req_refused(req_refused),
        .key_valid(key_valid), .key_data(key_data), .req_valid(req_valid), .req_op(req_op),
        .req_addr(req_addr), .req_data(req_data));
    task summarize;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize
    task chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value at %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        rd_valid <= 1'b1;
        rd_addr <= a;
        @(posedge clk);
        rd_valid <= 1'b0;
        #1;
        chk({7'h0, rd_ack}, 8'h01);
        chk(rd_data, e);
    endtask : rd
    task op(input prog_mode_t m, input op_t o, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        mode <= m;
        tool.unlock(UNLOCK_KEY2);
        tool.request(o, a, d, r);
    endtask : op
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        repeat (60000) @(posedge clk);
        n_fail++;
        summarize();
    end
    initial
    begin
        srst = 1'b1;
        mode = MODE_USER;
        rd_valid = 1'b0;
        rd_addr = 16'h0000;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        #1;
        chk({unlocked, busy, req_done, req_refused}, 8'h00);
        foreach (rows[i])
        begin
            op(rows[i].m, rows[i].op, rows[i].a, rows[i].d);
            chk({6'h0, r}, {6'h0, rows[i].r});
            if (rows[i].r == 2'h2 && rows[i].op == OP_PROGRAM)
                rd(rows[i].a, rows[i].d);
        end
        chk(option1, 8'h77);
        tool.request(OP_PROGRAM, 16'h8000, 8'h00, r);
        chk({6'h0, r}, 8'h01);
        tool.unlock(8'h00);
        tool.request(OP_PROGRAM, 16'h8000, 8'h00, r);
        chk({6'h0, r}, 8'h01);
        rd(16'h8000, 8'ha5);
        op(MODE_TOOL, OP_PROGRAM, 16'h7fff, 8'h00);
        chk({6'h0, r}, 8'h01);
        op(MODE_IAP, OP_ERASE_SECTOR, 16'he800, 8'h00);
        chk({6'h0, r}, 8'h02);
        @(posedge clk);
        rd(16'he001, ERASED_BYTE);
        rd(16'hdfff, 8'h5a);
        rd(16'hf000, 8'h3c);
        op(MODE_TOOL, OP_PROGRAM_OPTION, 16'h0000, 8'h01);
        chk(option0, 8'h01);
        op(MODE_TOOL, OP_PROGRAM_OPTION, 16'h0000, 8'h00);
        chk({6'h0, r}, 8'h02);
        @(posedge clk);
        chk(option0, 8'h00);
        rd(16'h8000, ERASED_BYTE);
        rd(16'hf000, ERASED_BYTE);
        summarize();
    end
endmodule : flash_sector_access_guard_tb_top

// file: test/flash_tool_model.sv
// Programming tool model: security sequence and write requests
`timescale 1ns/1ps
module flash_tool_model
    import flash_guard_pkg::*;
(
    input wire logic clk,
    input wire logic req_done,
    input wire logic req_refused,
    output logic key_valid,
    output logic [7:0] key_data,
    output logic req_valid,
    output op_t req_op,
    output logic [15:0] req_addr,
    output logic [7:0] req_data
);
    initial
    begin
        key_valid = 1'b0;
        key_data = 8'h00;
        req_valid = 1'b0;
        req_op = OP_PROGRAM;
        req_addr = 16'h0000;
        req_data = 8'h00;
    end
    task unlock(input logic [7:0] k2);
        @(posedge clk);
        key_valid <= 1'b1;
        key_data <= UNLOCK_KEY1;
        @(posedge clk);
        key_data <= k2;
        @(posedge clk);
        key_valid <= 1'b0;
        key_data <= ~k2;
    endtask : unlock
    task request(input op_t op, input logic [15:0] a, input logic [7:0] d,
        output logic [1:0] r);
        int i;
        @(posedge clk);
        req_valid <= 1'b1;
        req_op <= op;
        req_addr <= a;
        req_data <= d;
        @(posedge clk);
        req_valid <= 1'b0;
        req_addr <= ~a;
        req_data <= ~d;
        #1;
        r = {req_done, req_refused};
        for (i = 0; i < 40000 && r == 2'h0; i++)
        begin
            @(posedge clk);
            #1;
            r = {req_done, req_refused};
        end
    endtask : request
endmodule : flash_tool_model
